// ### rtl/hlt_pkg.sv
/*
 * Shared constants and types for the hardware-limit period timer.
 * Assumes a single 25 MHz core clock that is also the system clock.
 */
package hlt_pkg;
	// register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] OFF_CLKSEL = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_LIMIT = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0C;
	localparam logic [7:0] OFF_PERIOD = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	// reset values
	localparam logic [3:0] RST_CLKSEL = 4'h0;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_LIMIT = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hFF;
	// status field position
	localparam int STATUS_EVENT_BIT = 0;
	// clock source codes
	localparam logic [3:0] CS_PIN = 4'h0;
	localparam logic [3:0] CS_INSTR = 4'h1;
	localparam logic [3:0] CS_SYSTEM = 4'h2;
	localparam logic [3:0] CS_HF_OSC = 4'h3;
	localparam logic [3:0] CS_LF_OSC = 4'h4;
	localparam logic [3:0] CS_MF_OSC = 4'h5;
	localparam logic [3:0] CS_SEC_OSC = 4'h6;
	localparam logic [3:0] CS_REF_CLK = 4'h7;
	localparam logic [3:0] CS_OSC_CTRL = 4'h8;
	localparam logic [3:0] CS_ZERO_CROSS = 4'h9;
	localparam logic [3:0] CS_LOGIC_CELL4 = 4'hD;
	// control mode codes
	localparam logic [4:0] MODE_FREE_RUN = 5'h00;
	localparam logic [4:0] MODE_LEVEL_LOW = 5'h06;
	localparam logic [4:0] MODE_LEVEL_HIGH = 5'h07;
	localparam logic [4:0] MODE_ONE_SHOT = 5'h08;
	// timing counts
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam int RUN_SYNC_STAGES = 2;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control register layout, bit 7 first
	typedef struct packed {
		logic on;
		logic [2:0] prescaleRatioField;
		logic [3:0] postscaleRatioField;
	} hlt_ctrl_t;
	// hardware limit register layout, bit 7 first
	typedef struct packed {
		logic prescalerSyncEnable;
		logic clockEdgePolarity;
		logic runBitSyncEnable;
		logic [4:0] mode;
	} hlt_limit_t;
endpackage : hlt_pkg

// ### rtl/hlt_prescaler.sv
/*
 * Input prescaler: passes one tick in every 2**ratio input ticks.
 * Assumes tickIn is a one-cycle enable in the core clock domain.
 */
`timescale 1ns/1ns
module hlt_prescaler import hlt_pkg::*; #(
	parameter int RATIO_W = 3
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic tickIn,
	input wire logic [RATIO_W-1:0] ratio,
	output logic tickOut
);
	localparam int CNT_W = (1 << RATIO_W) - 1;
	logic [CNT_W-1:0] divCnt_reg; // ticks seen so far
	logic [CNT_W-1:0] divCnt_next;
	logic [CNT_W-1:0] limit; // last count before a pass

	// terminal count and next count
	always_comb begin
		limit = CNT_W'((32'd1 << ratio) - 32'd1);
		// at or past the limit, so a ratio lowered while running still passes
		tickOut = tickIn & ~clear & (divCnt_reg >= limit);
		divCnt_next = divCnt_reg;
		if (clear) begin
			divCnt_next = '0;
		end else if (tickIn) begin
			divCnt_next = tickOut ? '0 : divCnt_reg + 1'b1;
		end
	end

	// count register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			divCnt_reg <= '0;
		end else begin
			divCnt_reg <= divCnt_next;
		end
	end

	a_prescale_unity: assert property (@(posedge core_clk) disable iff (rst)
		(ratio == '0 && tickIn && !clear) |-> tickOut)
		else $error("unity prescale dropped a tick");
endmodule : hlt_prescaler

// ### rtl/hlt_postscaler.sv
/*
 * Output postscaler: one pulse for every ratio+1 period matches.
 * Assumes matchIn is a one-cycle pulse in the core clock domain.
 */
`timescale 1ns/1ns
module hlt_postscaler import hlt_pkg::*; #(
	parameter int RATIO_W = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic matchIn,
	input wire logic [RATIO_W-1:0] ratio,
	output logic pulseOut
);
	logic [RATIO_W-1:0] matchCnt_reg; // matches seen so far
	logic [RATIO_W-1:0] matchCnt_next;

	// pulse on the (ratio+1)-th match, then restart
	always_comb begin
		// at or past the ratio, so a ratio lowered while running still pulses
		pulseOut = matchIn & ~clear & (matchCnt_reg >= ratio);
		matchCnt_next = matchCnt_reg;
		if (clear) begin
			matchCnt_next = '0;
		end else if (matchIn) begin
			matchCnt_next = pulseOut ? '0 : matchCnt_reg + 1'b1;
		end
	end

	// count register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			matchCnt_reg <= '0;
		end else begin
			matchCnt_reg <= matchCnt_next;
		end
	end
endmodule : hlt_postscaler

// ### rtl/hlt_timer.sv
/*
 * 8-bit period timer with hardware-limit control, AXI4-Lite registers.
 * Assumes core_clk is the system clock, all inputs synchronous to it,
 * and clock sources sampled as levels (at most one edge per cycle).
 */
`timescale 1ns/1ns
module hlt_timer import hlt_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [15:0] clockSources,
	input wire logic externalResetSignal,
	input wire logic sleepMode,
	output logic timerOutPulse,
	output logic timerEventFlag,
	output logic keepLowFreqOsc,
	output logic keepMidFreqOsc,
	output logic keepHighFreqOsc
);
	// software-visible registers
	logic [3:0] clkSel_reg, clkSel_next; // clock source select
	hlt_ctrl_t ctrl_reg, ctrl_next; // run, prescale, postscale
	hlt_limit_t limit_reg, limit_next; // sync, polarity, mode
	logic [7:0] countValue_reg, countValue_next; // timer count
	logic [7:0] periodValue_reg, periodValue_next; // period
	logic eventFlag_reg, eventFlag_next; // sticky match event
	// bus slave state
	logic awReady_reg, awReady_next;
	logic wReady_reg, wReady_next;
	logic awHeld_reg, awHeld_next; // address taken, waiting for data
	logic wHeld_reg, wHeld_next; // data taken, waiting for address
	logic [7:0] wrAddr_reg, wrAddr_next;
	logic [7:0] wrData_reg, wrData_next;
	logic wrStrb_reg, wrStrb_next; // low byte lane enable
	logic bValid_reg, bValid_next;
	logic [1:0] bResp_reg, bResp_next;
	logic arReady_reg, arReady_next;
	logic rValid_reg, rValid_next;
	logic [31:0] rData_reg, rData_next;
	logic [1:0] rResp_reg, rResp_next;
	// timing chain state
	logic [1:0] instrDiv_reg, instrDiv_next; // system clock divide by four
	logic srcPrev_reg, srcPrev_next; // last sample of selected source
	logic prePending_reg, prePending_next; // prescaler tick awaiting sync
	logic [RUN_SYNC_STAGES-1:0] runPipe_reg, runPipe_next; // run sync
	logic outPulse_reg, outPulse_next;
	logic keepLf_reg, keepLf_next;
	logic keepMf_reg, keepMf_next;
	logic keepHf_reg, keepHf_next;
	// combinational helpers
	logic instrEn; // instruction clock enable
	logic srcLevel; // selected source level
	logic srcTick; // active edge of the timer input clock
	logic sleepBlock; // timer frozen by sleep
	logic tickIn; // tick presented to the prescaler
	logic preTick; // prescaler output
	logic syncTick; // prescaler output after optional sync
	logic runEff; // run bit as seen by the counter
	logic cntTick; // counter clock
	logic levelHold; // level-triggered reset active
	logic matchPulse; // period match on a counter clock
	logic postPulse; // postscaler output
	logic awTake, wTake, wrCommit, arTake;
	logic wrOk; // write address mapped

	assign awready = awReady_reg;
	assign wready = wReady_reg;
	assign bvalid = bValid_reg;
	assign bresp = bResp_reg;
	assign arready = arReady_reg;
	assign rvalid = rValid_reg;
	assign rdata = rData_reg;
	assign rresp = rResp_reg;
	assign timerOutPulse = outPulse_reg;
	assign timerEventFlag = eventFlag_reg;
	assign keepLowFreqOsc = keepLf_reg;
	assign keepMidFreqOsc = keepMf_reg;
	assign keepHighFreqOsc = keepHf_reg;

	// clock source selection and edge detection
	always_comb begin
		instrEn = (instrDiv_reg == INSTR_DIV_LAST);
		instrDiv_next = instrDiv_reg + 1'b1;
		srcLevel = clockSources[clkSel_reg];
		srcPrev_next = srcLevel;
		unique case (clkSel_reg)
			CS_INSTR: srcTick = instrEn;
			CS_SYSTEM: srcTick = 1'b1;
			4'hE, 4'hF: srcTick = 1'b0; // reserved codes never tick
			default: begin
				// falling edge when polarity set, else rising
				srcTick = limit_reg.clockEdgePolarity ? (srcPrev_reg & ~srcLevel)
					: (~srcPrev_reg & srcLevel);
			end
		endcase
		sleepBlock = sleepMode & limit_reg.prescalerSyncEnable;
		tickIn = srcTick & ~sleepBlock;
	end

	hlt_prescaler #(
		.RATIO_W(3)
	) u_prescaler (
		.core_clk(core_clk),
		.rst(rst),
		.clear(~ctrl_reg.on),
		.tickIn(tickIn),
		.ratio(ctrl_reg.prescaleRatioField),
		.tickOut(preTick)
	);

	// prescaler sync, run sync, counter and mode logic
	always_comb begin
		// hold a prescaler tick until the next instruction clock
		prePending_next = prePending_reg;
		if (!ctrl_reg.on || !limit_reg.prescalerSyncEnable) begin
			prePending_next = 1'b0;
		end else if (instrEn) begin
			prePending_next = 1'b0;
		end else if (preTick) begin
			prePending_next = 1'b1;
		end
		syncTick = limit_reg.prescalerSyncEnable ?
			(instrEn & (prePending_reg | preTick)) : preTick;
		// run bit shifted through two input clocks when synced
		runPipe_next = runPipe_reg;
		if (srcTick) begin
			runPipe_next = {runPipe_reg[RUN_SYNC_STAGES-2:0], ctrl_reg.on};
		end
		runEff = limit_reg.runBitSyncEnable ? runPipe_reg[RUN_SYNC_STAGES-1]
			: ctrl_reg.on;
		cntTick = syncTick & runEff & ~sleepBlock;
		// level modes: ignored while the run bit is clear
		unique case (limit_reg.mode)
			MODE_LEVEL_LOW: levelHold = ctrl_reg.on & ~externalResetSignal;
			MODE_LEVEL_HIGH: levelHold = ctrl_reg.on & externalResetSignal;
			default: levelHold = 1'b0;
		endcase
		levelHold = levelHold & ~sleepBlock;
		matchPulse = cntTick & ~levelHold & (countValue_reg == periodValue_reg);
		countValue_next = countValue_reg; // halting keeps the count
		if (levelHold) begin
			countValue_next = '0;
		end else if (matchPulse) begin
			countValue_next = '0;
		end else if (cntTick) begin
			countValue_next = countValue_reg + 1'b1;
		end
	end

	hlt_postscaler #(
		.RATIO_W(4)
	) u_postscaler (
		.core_clk(core_clk),
		.rst(rst),
		.clear(~ctrl_reg.on),
		.matchIn(matchPulse),
		.ratio(ctrl_reg.postscaleRatioField),
		.pulseOut(postPulse)
	);

	// bus slave: write and read channels
	always_comb begin
		awTake = awvalid & awReady_reg;
		wTake = wvalid & wReady_reg;
		awHeld_next = awHeld_reg | awTake;
		wHeld_next = wHeld_reg | wTake;
		wrAddr_next = awTake ? awaddr : wrAddr_reg;
		wrData_next = wTake ? wdata[7:0] : wrData_reg;
		wrStrb_next = wTake ? wstrb[0] : wrStrb_reg;
		wrCommit = awHeld_next & wHeld_next & ~bValid_reg;
		wrOk = (wrAddr_next == OFF_CLKSEL) || (wrAddr_next == OFF_CTRL)
			|| (wrAddr_next == OFF_LIMIT) || (wrAddr_next == OFF_COUNT)
			|| (wrAddr_next == OFF_PERIOD) || (wrAddr_next == OFF_STATUS);
		bValid_next = bValid_reg & ~bready;
		bResp_next = bResp_reg;
		if (wrCommit) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bValid_next = 1'b1;
			bResp_next = wrOk ? RESP_OKAY : RESP_SLVERR;
		end
		awReady_next = ~awHeld_next & ~bValid_next;
		wReady_next = ~wHeld_next & ~bValid_next;
		// read: one cycle from address to data
		arTake = arvalid & arReady_reg;
		rValid_next = rValid_reg & ~rready;
		rData_next = rData_reg;
		rResp_next = rResp_reg;
		if (arTake) begin
			rValid_next = 1'b1;
			rResp_next = RESP_OKAY;
			unique case (araddr)
				OFF_CLKSEL: rData_next = {28'h0000000, clkSel_reg};
				OFF_CTRL: rData_next = {24'h000000, ctrl_reg};
				OFF_LIMIT: rData_next = {24'h000000, limit_reg};
				OFF_COUNT: rData_next = {24'h000000, countValue_reg};
				OFF_PERIOD: rData_next = {24'h000000, periodValue_reg};
				OFF_STATUS: rData_next = {31'h00000000, eventFlag_reg};
				default: begin
					rData_next = 32'h00000000;
					rResp_next = RESP_SLVERR;
				end
			endcase
		end
		arReady_next = ~rValid_next;
	end

	// register writes, hardware clear of run bit, event flag, outputs
	always_comb begin
		clkSel_next = clkSel_reg;
		ctrl_next = ctrl_reg;
		limit_next = limit_reg;
		periodValue_next = periodValue_reg;
		// one-shot: hardware drops the run bit on the match
		if (matchPulse && limit_reg.mode == MODE_ONE_SHOT) begin
			ctrl_next.on = 1'b0;
		end
		eventFlag_next = eventFlag_reg;
		if (wrCommit && wrStrb_next) begin
			unique case (wrAddr_next)
				OFF_CLKSEL: clkSel_next = wrData_next[3:0];
				OFF_CTRL: ctrl_next = hlt_ctrl_t'(wrData_next); // software write wins
				OFF_LIMIT: limit_next = hlt_limit_t'(wrData_next);
				OFF_PERIOD: periodValue_next = wrData_next;
				OFF_STATUS: begin
					if (wrData_next[STATUS_EVENT_BIT]) begin
						eventFlag_next = 1'b0; // write one to clear
					end
				end
				default: ;
			endcase
		end
		if (postPulse) begin
			eventFlag_next = 1'b1; // set beats clear
		end
		outPulse_next = postPulse;
		keepLf_next = sleepMode & ctrl_reg.on & (clkSel_reg == CS_LF_OSC);
		keepMf_next = sleepMode & ctrl_reg.on & (clkSel_reg == CS_MF_OSC);
		keepHf_next = sleepMode & ctrl_reg.on & (clkSel_reg == CS_HF_OSC);
	end

	// all state registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clkSel_reg <= RST_CLKSEL;
			ctrl_reg <= hlt_ctrl_t'(RST_CTRL);
			limit_reg <= hlt_limit_t'(RST_LIMIT);
			countValue_reg <= RST_COUNT;
			periodValue_reg <= RST_PERIOD;
			eventFlag_reg <= 1'b0;
			awReady_reg <= 1'b0;
			wReady_reg <= 1'b0;
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
			wrData_reg <= 8'h00;
			wrStrb_reg <= 1'b0;
			bValid_reg <= 1'b0;
			bResp_reg <= RESP_OKAY;
			arReady_reg <= 1'b0;
			rValid_reg <= 1'b0;
			rData_reg <= 32'h00000000;
			rResp_reg <= RESP_OKAY;
			instrDiv_reg <= 2'h0;
			srcPrev_reg <= 1'b0;
			prePending_reg <= 1'b0;
			runPipe_reg <= '0;
			outPulse_reg <= 1'b0;
			keepLf_reg <= 1'b0;
			keepMf_reg <= 1'b0;
			keepHf_reg <= 1'b0;
		end else begin
			clkSel_reg <= clkSel_next;
			ctrl_reg <= ctrl_next;
			limit_reg <= limit_next;
			countValue_reg <= countValue_next;
			periodValue_reg <= periodValue_next;
			eventFlag_reg <= eventFlag_next;
			awReady_reg <= awReady_next;
			wReady_reg <= wReady_next;
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			wrAddr_reg <= wrAddr_next;
			wrData_reg <= wrData_next;
			wrStrb_reg <= wrStrb_next;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			arReady_reg <= arReady_next;
			rValid_reg <= rValid_next;
			rData_reg <= rData_next;
			rResp_reg <= rResp_next;
			instrDiv_reg <= instrDiv_next;
			srcPrev_reg <= srcPrev_next;
			prePending_reg <= prePending_next;
			runPipe_reg <= runPipe_next;
			outPulse_reg <= outPulse_next;
			keepLf_reg <= keepLf_next;
			keepMf_reg <= keepMf_next;
			keepHf_reg <= keepHf_next;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_sync_run_set;
		$rose(ctrl_reg.on) && limit_reg.runBitSyncEnable && (runPipe_reg == '0);
	endsequence

	a_sleep_frozen: assert property (
		sleepBlock |=> $stable(countValue_reg))
		else $error("count moved in sleep with synced prescaler");
	a_sleep_counting: assert property (
		(sleepMode && cntTick && !levelHold && countValue_reg != periodValue_reg)
		|=> countValue_reg == $past(countValue_reg) + 8'h01)
		else $error("count did not advance in sleep");
	a_osc_kept_low: assert property (
		(sleepMode && ctrl_reg.on && clkSel_reg == CS_LF_OSC) |=> keepLowFreqOsc)
		else $error("selected low oscillator not kept in sleep");
	a_off_no_count: assert property (
		(!ctrl_reg.on && !limit_reg.runBitSyncEnable) |-> !cntTick)
		else $error("counter ticked while off");
	a_period_wrap: assert property (
		(cntTick && !levelHold && countValue_reg == periodValue_reg) |=> countValue_reg == 8'h00)
		else $error("period match did not clear count");
	a_oneshot_stop: assert property (
		(matchPulse && limit_reg.mode == MODE_ONE_SHOT && !wrCommit)
		|=> !ctrl_reg.on ##1 !ctrl_reg.on || $past(wrCommit))
		else $error("one-shot did not clear the run bit");
	a_level_reset: assert property (
		(ctrl_reg.on && !sleepBlock && limit_reg.mode == MODE_LEVEL_HIGH && externalResetSignal)
		|=> countValue_reg == 8'h00)
		else $error("high level did not hold count in reset");
	a_run_sync_delay: assert property (
		s_sync_run_set |-> !runEff ##1 !runEff)
		else $error("synced start came too early");
	a_postscale_unity: assert property (
		(matchPulse && ctrl_reg.on && ctrl_reg.postscaleRatioField == 4'h0)
		|=> timerOutPulse && timerEventFlag)
		else $error("unity postscale lost a match");
endmodule : hlt_timer

// ### test/hlt_tb.sv
/*
 * Self-checking bench for the hardware-limit period timer.
 * Assumes the package and timer files are compiled first; the bench
 * drives the register bus and every clock source line itself.
 */
`timescale 1ns/1ns
module tb import hlt_pkg::*;;
	logic core_clk = 1'b0; // 25 MHz core clock
	logic rst = 1'b1; // synchronous reset
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [15:0] clockSources = 16'h0; // source lines, all idle low
	logic extRst = 1'b0; // external reset level
	logic sleepMode = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic timerOutPulse, timerEventFlag;
	logic keepLowFreqOsc, keepMidFreqOsc, keepHighFreqOsc;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] rv; // last read data
	logic [1:0] rs; // last response code
	int nFail = 0;
	int nCompared = 0;
	int nPulse = 0; // output pulses seen

	always #20 core_clk = ~core_clk;

	// count timer output pulses
	always @(posedge core_clk) begin
		if (timerOutPulse === 1'b1) nPulse++;
	end

	hlt_timer DUT (.core_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .clockSources, .externalResetSignal(extRst), .sleepMode,
		.timerOutPulse, .timerEventFlag, .keepLowFreqOsc, .keepMidFreqOsc, .keepHighFreqOsc);

	// count after a number of timer ticks from zero
	function automatic logic [31:0] expCount(input int t, input int per);
		return t % (per + 1);
	endfunction : expCount

	// output pulses after a number of ticks
	function automatic logic [31:0] expPulses(input int t, input int per, input int q);
		return (t / (per + 1)) / (q + 1);
	endfunction : expPulses

	// verdict and end of run
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	// compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nFail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	// one bus write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		rs = bresp;
		if (i == 50) begin
			nFail++;
			finish_test();
		end
	endtask : wr

	// one bus read
	task automatic rd(input logic [7:0] a);
		int i;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		rv = rdata;
		rs = rresp;
		if (i == 50) begin
			nFail++;
			finish_test();
		end
	endtask : rd

	// read a register and compare
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
	endtask : rc

	// n full pulses on one source line, then settle
	task automatic edges(input int idx, input int n);
		repeat (n) begin
			@(posedge core_clk);
			clockSources[idx] <= 1'b1;
			repeat (2) @(posedge core_clk);
			clockSources[idx] <= 1'b0;
			repeat (1) @(posedge core_clk);
		end
		repeat (8) @(posedge core_clk);
	endtask : edges

	// clear the count through a level reset, leave timer off
	task automatic zero;
		wr(OFF_CTRL, 8'h00);
		wr(OFF_LIMIT, {3'h0, MODE_LEVEL_HIGH});
		extRst <= 1'b1;
		wr(OFF_CTRL, 8'h80);
		wr(OFF_CTRL, 8'h00);
		extRst <= 1'b0;
		wr(OFF_PERIOD, 8'hFF);
	endtask : zero

	initial begin
		int p, q, per, k, r, pol, lv, t, c;
		void'($urandom(32'h3EAB1BCB));
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		// reset values and bus corners
		rc(OFF_CLKSEL, 32'h00);
		rc(OFF_CTRL, 32'h00);
		rc(OFF_LIMIT, 32'h00);
		rc(OFF_COUNT, 32'h00);
		rc(OFF_PERIOD, 32'hFF);
		rc(8'h18, 32'h00);
		chk(rs, RESP_SLVERR);
		wr(OFF_COUNT, 8'h33);
		chk(rs, RESP_OKAY);
		rc(OFF_COUNT, 32'h00);
		wr(8'h18, 8'h5A);
		chk(rs, RESP_SLVERR);
		$display("test reset done");
		// random prescale, postscale, period, polarity and level mode
		for (int it = 0; it < 6; it++) begin
			p = $urandom % 4;
			q = $urandom % 4;
			per = 1 + $urandom % 6;
			k = 1 + $urandom % 2;
			r = $urandom % (per + 1);
			pol = $urandom % 2;
			lv = $urandom % 2;
			if (it == 0) p = 7;
			if (it == 1) q = 15;
			wr(OFF_CTRL, 8'h00);
			wr(OFF_PERIOD, per[7:0]);
			// polarity only changed while off
			wr(OFF_LIMIT, {1'b0, pol[0], 1'b0, lv[0] ? MODE_LEVEL_HIGH : MODE_LEVEL_LOW});
			extRst <= lv[0];
			wr(OFF_CTRL, {1'b1, p[2:0], q[3:0]});
			repeat (3) @(posedge core_clk);
			rc(OFF_COUNT, 32'h00);
			wr(OFF_STATUS, 8'h01);
			rc(OFF_STATUS, 32'h00);
			nPulse = 0;
			extRst <= ~lv[0];
			t = (per + 1) * (q + 1) * k + r;
			edges(0, t << p);
			rc(OFF_COUNT, expCount(t, per));
			chk(nPulse, expPulses(t, per, q));
			chk(timerEventFlag, 1'b1);
			rc(OFF_STATUS, 32'h01);
			wr(OFF_CTRL, 8'h00);
			extRst <= lv[0];
			edges(0, 2);
			rc(OFF_COUNT, expCount(t, per));
			$display("test random %0d done", it);
		end
		// every source code except instruction and system clock, reserved ones never tick
		for (c = 0; c < 16; c++) begin
			if (c == 1 || c == 2) continue;
			zero();
			wr(OFF_CLKSEL, c[7:0]);
			wr(OFF_LIMIT, 8'h00);
			wr(OFF_CTRL, 8'h80);
			edges(c, 3);
			rc(OFF_COUNT, (c > 13) ? 32'h00 : 32'h03);
		end
		$display("test sources done");
		// one-shot: run bit cleared at match, other fields kept
		zero();
		wr(OFF_CLKSEL, 8'h00);
		wr(OFF_PERIOD, 8'h03);
		wr(OFF_LIMIT, {3'h0, MODE_ONE_SHOT});
		wr(OFF_CTRL, 8'h83);
		edges(0, 4);
		rc(OFF_CTRL, 32'h03);
		edges(0, 2);
		rc(OFF_COUNT, 32'h00);
		wr(OFF_CTRL, 8'h83);
		edges(0, 2);
		rc(OFF_COUNT, 32'h02);
		$display("test one-shot done");
		// synchronised run bit starts after two input clocks
		zero();
		wr(OFF_LIMIT, 8'h20);
		// flush run sync stages with the run bit low, so the start is a clean one
		edges(0, 2);
		rc(OFF_COUNT, 32'h00);
		wr(OFF_CTRL, 8'h80);
		edges(0, 5);
		rc(OFF_COUNT, 32'h03);
		// synchronised prescaler ticks once per instruction clock
		zero();
		wr(OFF_CLKSEL, {4'h0, CS_SYSTEM});
		wr(OFF_LIMIT, 8'h80);
		wr(OFF_CTRL, 8'h80);
		repeat (40) @(posedge core_clk);
		wr(OFF_CTRL, 8'h00);
		rd(OFF_COUNT);
		chk(rv[7:0] > 8'h08 && rv[7:0] < 8'h0D, 1'b1);
		$display("test sync done");
		// sleep with and without prescaler sync
		zero();
		wr(OFF_CLKSEL, 8'h00);
		wr(OFF_LIMIT, 8'h80);
		wr(OFF_CTRL, 8'h80);
		sleepMode <= 1'b1;
		edges(0, 4);
		rc(OFF_COUNT, 32'h00);
		rc(OFF_PERIOD, 32'hFF);
		wr(OFF_LIMIT, 8'h00);
		edges(0, 4);
		rc(OFF_COUNT, 32'h04);
		// oscillator keep lines while asleep
		for (c = 3; c < 6; c++) begin
			wr(OFF_CLKSEL, c[7:0]);
			repeat (2) @(posedge core_clk);
			chk({keepHighFreqOsc, keepMidFreqOsc, keepLowFreqOsc},
				(c == 3) ? 3'h4 : (c == 4) ? 3'h1 : 3'h2);
		end
		sleepMode <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({keepHighFreqOsc, keepMidFreqOsc, keepLowFreqOsc}, 3'h0);
		$display("test sleep done");
		finish_test();
	end
endmodule : tb
